// >>> bootl_pkg.sv
// package for the byte boot loader
package bootl_pkg;
	localparam int ADDR_W = 24;
	localparam int WORD_W = 32;
	localparam int BYTES_PER_WORD = 4;
	localparam int WAIT_CYCLES = 16;
	localparam int IMEM_AW = 16;
	localparam logic [23:0] BOOT_BASE = 24'h00_0000;
	localparam logic [15:0] BOOT_WORDS_RST = 16'h0100;
	localparam logic [4:0] WAIT_RST = 5'h00;
	localparam logic [1:0] LANE_RST = 2'h0;
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_ADDR = 5'b00010,
		ST_WAIT = 5'b00100,
		ST_PUSH = 5'b01000,
		ST_DONE = 5'b10000
	} bootl_state_t;
endpackage : bootl_pkg

// >>> bootl_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module bootl_skid #(
	parameter int WIDTH = 48
) (
	input wire logic clock, // system clock
	input wire logic sys_rst, // sync reset
	input wire logic inValid, // word offered
	output logic inReady, // room for a word
	input wire logic [WIDTH-1:0] inData, // word in
	output logic outValid, // word held
	input wire logic outReady, // sink takes word
	output logic [WIDTH-1:0] outData // word out
);
	logic [WIDTH-1:0] mem_reg [2];
	logic [WIDTH-1:0] mem_next [2];
	logic rdPtr_reg, rdPtr_next, wrPtr_reg, wrPtr_next;
	logic [1:0] count_reg, count_next;
	logic doWr, doRd;

	if (WIDTH < 1) begin : g_badWidth
		$error("bad width");
	end

	always_comb begin
		doWr = inValid && (count_reg != 2'd2);
		doRd = (count_reg != 2'd0) && outReady;
		mem_next = mem_reg;
		if (doWr) begin
			mem_next[wrPtr_reg] = inData;
		end
		wrPtr_next = doWr ? ~wrPtr_reg : wrPtr_reg;
		rdPtr_next = doRd ? ~rdPtr_reg : rdPtr_reg;
		count_next = count_reg + {1'b0, doWr} - {1'b0, doRd};
	end

	always_ff @(posedge clock) begin
		mem_reg <= mem_next;
		if (sys_rst) begin
			rdPtr_reg <= 1'b0;
			wrPtr_reg <= 1'b0;
			count_reg <= 2'd0;
		end else begin
			rdPtr_reg <= rdPtr_next;
			wrPtr_reg <= wrPtr_next;
			count_reg <= count_next;
		end
	end

	assign inReady = (count_reg != 2'd2);
	assign outValid = (count_reg != 2'd0);
	assign outData = mem_reg[rdPtr_reg];

	property p_nofill;
		@(posedge clock) disable iff (sys_rst) (count_reg == 2'd2) |-> !inReady;
	endproperty
	a_nofill: assert property (p_nofill) else $error("full buffer accepts");
	property p_holdOut;
		@(posedge clock) disable iff (sys_rst)
		(outValid && !outReady) |=> (outValid && $stable(outData));
	endproperty
	a_holdOut: assert property (p_holdOut) else $error("stalled word lost");
endmodule : bootl_skid

// >>> bootl_loader.sv
// byte EPROM boot loader: reads bytes, packs words, writes internal memory
// Notes on behaviour
// - configured for byte EPROM boot, load program after reset without core help
// - each boot memory read waits sixteen cycles before sampling the byte
// - boot memory select acts as EPROM chip select during boot
// - channel zero packs four bytes into each 32-bit word before writing
// - byte address is 24 bits, sixteen megabytes span
// - EPROM space is not reachable by ordinary core loads and stores
// - after boot, DMA requests may still read and write the EPROM
`timescale 1ns/1ns
module bootl_loader #(
	parameter int BOOT_WORDS = 256
) (
	input wire logic clock, // 25 MHz system clock
	input wire logic sys_rst, // sync reset, active high
	input wire logic bootEpromStrap, // strap: boot from byte EPROM
	input wire logic [7:0] romDataIn, // EPROM data pins
	output logic [7:0] romDataOut, // data driven for flash writes
	output logic romDataOe, // high while driving data pins
	output logic [23:0] romAddr, // EPROM byte address
	output logic boot_memory_select_n, // EPROM chip select, active low
	output logic romRead_n, // read strobe, active low
	output logic romWrite_n, // write strobe, active low
	output logic memWrValid, // internal memory write request
	output logic [15:0] memWrAddr, // internal memory word address
	output logic [31:0] memWrData, // packed instruction word
	input wire logic memWrReady, // internal memory takes write
	output logic bootDone, // boot finished
	input wire logic dmaReq, // post-boot DMA byte access request
	input wire logic dmaWrite, // 1 write, 0 read
	input wire logic [23:0] dmaAddr, // DMA byte address
	input wire logic [7:0] dmaWrData, // DMA write byte
	output logic dmaAck, // DMA access finished, one cycle
	output logic [7:0] dmaRdData // DMA read byte
);
	localparam int CW = $clog2(bootl_pkg::WAIT_CYCLES + 1);
	if (BOOT_WORDS < 1 || BOOT_WORDS > 65536) begin : g_badLen
		$error("bad boot length");
	end

	// strap synchroniser, change counts when second and third agree
	logic [2:0] strapSync_reg;
	logic strapLvl_reg, strapLvl_next;
	always_comb begin
		strapLvl_next = (strapSync_reg[1] == strapSync_reg[2]) ? strapSync_reg[2] : strapLvl_reg;
	end
	always_ff @(posedge clock) begin
		strapSync_reg <= {strapSync_reg[1:0], bootEpromStrap};
		strapLvl_reg <= sys_rst ? 1'b0 : strapLvl_next;
	end

	// data pin synchroniser
	logic [7:0] dSync0_reg, dSync1_reg, dSync2_reg;
	always_ff @(posedge clock) begin
		dSync0_reg <= romDataIn;
		dSync1_reg <= dSync0_reg;
		dSync2_reg <= dSync1_reg;
	end

	bootl_pkg::bootl_state_t state_reg, state_next;
	logic [23:0] addr_reg, addr_next;
	logic [CW-1:0] wait_reg, wait_next;
	logic [1:0] lane_reg, lane_next;
	logic [31:0] pack_reg, pack_next;
	logic [15:0] word_reg, word_next;
	logic booting_reg, booting_next;
	logic dmaCyc_reg, dmaCyc_next, dmaWr_reg, dmaWr_next;
	logic startDly_reg, startDly_next;
	logic selN_reg, selN_next, rdN_reg, rdN_next, wrN_reg, wrN_next, oe_reg, oe_next;
	logic [7:0] dOut_reg, dOut_next, dmaRd_reg, dmaRd_next;
	logic ack_reg, ack_next, done_reg, done_next;
	logic pushValid, pushReady;
	logic [47:0] pushData, bufData, mwD_reg;
	logic bufValid, bufTake, mwV_reg;
	localparam logic [15:0] LAST_WORD = 16'(BOOT_WORDS - 1);

	always_comb begin
		state_next = state_reg;
		addr_next = addr_reg;
		wait_next = wait_reg;
		lane_next = lane_reg;
		pack_next = pack_reg;
		word_next = word_reg;
		booting_next = booting_reg;
		dmaCyc_next = dmaCyc_reg;
		dmaWr_next = dmaWr_reg;
		startDly_next = 1'b1;
		selN_next = selN_reg;
		rdN_next = rdN_reg;
		wrN_next = wrN_reg;
		oe_next = oe_reg;
		dOut_next = dOut_reg;
		dmaRd_next = dmaRd_reg;
		ack_next = 1'b0;
		done_next = done_reg;
		pushValid = 1'b0;
		pushData = {word_reg, pack_reg};
		unique case (state_reg)
			bootl_pkg::ST_IDLE: begin
				if (!startDly_reg) begin
					state_next = bootl_pkg::ST_IDLE;
				end else if (strapLvl_reg && !done_reg) begin
					booting_next = 1'b1;
					addr_next = bootl_pkg::BOOT_BASE;
					state_next = bootl_pkg::ST_ADDR;
				end else if (done_reg && !ack_reg && dmaReq) begin
					dmaCyc_next = 1'b1;
					dmaWr_next = dmaWrite;
					addr_next = dmaAddr;
					dOut_next = dmaWrData;
					state_next = bootl_pkg::ST_ADDR;
				end else begin
					done_next = 1'b1;
				end
			end
			bootl_pkg::ST_ADDR: begin
				selN_next = 1'b0;
				rdN_next = dmaWr_reg && dmaCyc_reg;
				wrN_next = !(dmaWr_reg && dmaCyc_reg);
				oe_next = dmaWr_reg && dmaCyc_reg;
				wait_next = CW'(bootl_pkg::WAIT_CYCLES - 1);
				state_next = bootl_pkg::ST_WAIT;
			end
			bootl_pkg::ST_WAIT: begin
				if (wait_reg != '0) begin
					wait_next = wait_reg - CW'(1);
				end else begin
					selN_next = 1'b1;
					rdN_next = 1'b1;
					wrN_next = 1'b1;
					oe_next = 1'b0;
					if (dmaCyc_reg) begin
						dmaRd_next = dSync2_reg;
						ack_next = 1'b1;
						dmaCyc_next = 1'b0;
						dmaWr_next = 1'b0;
						state_next = bootl_pkg::ST_IDLE;
					end else begin
						pack_next[lane_reg*8 +: 8] = dSync2_reg;
						lane_next = lane_reg + 2'd1;
						addr_next = addr_reg + 24'd1;
						state_next = (lane_reg == 2'd3) ? bootl_pkg::ST_PUSH : bootl_pkg::ST_ADDR;
					end
				end
			end
			bootl_pkg::ST_PUSH: begin
				pushValid = 1'b1;
				if (pushReady) begin
					word_next = word_reg + 16'd1;
					if (word_reg == LAST_WORD) begin
						booting_next = 1'b0;
						state_next = bootl_pkg::ST_DONE;
					end else begin
						state_next = bootl_pkg::ST_ADDR;
					end
				end
			end
			bootl_pkg::ST_DONE: begin
				if (!bufValid && !mwV_reg) begin
					done_next = 1'b1;
					state_next = bootl_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_reg <= bootl_pkg::ST_IDLE;
			addr_reg <= bootl_pkg::BOOT_BASE;
			wait_reg <= '0;
			lane_reg <= bootl_pkg::LANE_RST;
			pack_reg <= 32'h0000_0000;
			word_reg <= 16'h0000;
			booting_reg <= 1'b0;
			dmaCyc_reg <= 1'b0;
			dmaWr_reg <= 1'b0;
			startDly_reg <= 1'b0;
			selN_reg <= 1'b1;
			rdN_reg <= 1'b1;
			wrN_reg <= 1'b1;
			oe_reg <= 1'b0;
			dOut_reg <= 8'h00;
			dmaRd_reg <= 8'h00;
			ack_reg <= 1'b0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			addr_reg <= addr_next;
			wait_reg <= wait_next;
			lane_reg <= lane_next;
			pack_reg <= pack_next;
			word_reg <= word_next;
			booting_reg <= booting_next;
			dmaCyc_reg <= dmaCyc_next;
			dmaWr_reg <= dmaWr_next;
			startDly_reg <= startDly_next;
			selN_reg <= selN_next;
			rdN_reg <= rdN_next;
			wrN_reg <= wrN_next;
			oe_reg <= oe_next;
			dOut_reg <= dOut_next;
			dmaRd_reg <= dmaRd_next;
			ack_reg <= ack_next;
			done_reg <= done_next;
		end
	end

	// word buffer toward internal memory; only this loader writes it
	bootl_skid #(.WIDTH(48)) u_buf (
		.clock(clock),
		.sys_rst(sys_rst),
		.inValid(pushValid),
		.inReady(pushReady),
		.inData(pushData),
		.outValid(bufValid),
		.outReady(bufTake),
		.outData(bufData)
	);

	// output stage reloads only when empty or taken, so no word is repeated
	assign bufTake = !mwV_reg || memWrReady;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			mwV_reg <= 1'b0;
			mwD_reg <= 48'h0000_0000_0000;
		end else if (bufTake) begin
			mwV_reg <= bufValid;
			mwD_reg <= bufData;
		end
	end
	assign memWrValid = mwV_reg;
	assign memWrAddr = mwD_reg[47:32];
	assign memWrData = mwD_reg[31:0];
	assign romAddr = addr_reg;
	assign boot_memory_select_n = selN_reg;
	assign romRead_n = rdN_reg;
	assign romWrite_n = wrN_reg;
	assign romDataOe = oe_reg;
	assign romDataOut = dOut_reg;
	assign dmaAck = ack_reg;
	assign dmaRdData = dmaRd_reg;
	assign bootDone = done_reg;

	property p_wait16;
		@(posedge clock) disable iff (sys_rst)
		$fell(selN_reg) |-> !selN_reg [*8] ##1 !selN_reg [*8] ##1 selN_reg;
	endproperty
	a_wait16: assert property (p_wait16) else $error("strobe not sixteen cycles");
	property p_selBoot;
		@(posedge clock) disable iff (sys_rst)
		(state_reg == bootl_pkg::ST_WAIT && booting_reg) |-> !selN_reg;
	endproperty
	a_selBoot: assert property (p_selBoot) else $error("select idle in boot read");
	property p_lsbFirst;
		@(posedge clock) disable iff (sys_rst)
		(state_reg == bootl_pkg::ST_WAIT && wait_reg == '0 && !dmaCyc_reg && lane_reg == 2'd0)
		|=> pack_reg[7:0] == $past(dSync2_reg);
	endproperty
	a_lsbFirst: assert property (p_lsbFirst) else $error("first byte not low lane");
	property p_push;
		@(posedge clock) disable iff (sys_rst)
		(pushValid && pushReady) |=> lane_reg == 2'd0;
	endproperty
	a_push: assert property (p_push) else $error("push mid word");
	property p_addrInc;
		@(posedge clock) disable iff (sys_rst)
		(state_reg == bootl_pkg::ST_WAIT && wait_reg == '0 && !dmaCyc_reg)
		|=> addr_reg == $past(addr_reg) + 24'd1;
	endproperty
	a_addrInc: assert property (p_addrInc) else $error("byte address not stepped");
	property p_dmaAck;
		@(posedge clock) disable iff (sys_rst)
		(state_reg == bootl_pkg::ST_IDLE && startDly_reg && done_reg && !ack_reg
			&& dmaReq)
		|-> ##[17:19] ack_reg;
	endproperty
	a_dmaAck: assert property (p_dmaAck) else $error("dma access not finished");
	property p_noDmaInBoot;
		@(posedge clock) disable iff (sys_rst) booting_reg |-> !dmaCyc_reg;
	endproperty
	a_noDmaInBoot: assert property (p_noDmaInBoot) else $error("dma during boot");
	property p_oe;
		@(posedge clock) disable iff (sys_rst) oe_reg |-> (!wrN_reg && !selN_reg);
	endproperty
	a_oe: assert property (p_oe) else $error("data driven outside write");
	c_boot: cover property (@(posedge clock) $rose(done_reg) && strapLvl_reg);
	c_stall: cover property (@(posedge clock) pushValid && !pushReady);
	c_dmaWr: cover property (@(posedge clock) ack_reg && !$past(wrN_reg));
	c_dmaRd: cover property (@(posedge clock) ack_reg);
endmodule : bootl_loader

// >>> bootl_rom_model.sv
// behavioural byte-wide EPROM or flash at the far side of the loader
`timescale 1ns/1ns
module bootl_rom_model #(
	parameter int ACCESS_CYC = 6
) (
	input wire logic clock, // system clock
	input wire logic selN, // chip select, active low
	input wire logic readN, // read strobe, active low
	input wire logic writeN, // write strobe, active low
	input wire logic [23:0] addr, // byte address
	input wire logic [7:0] wrData, // byte from loader
	input wire logic wrOe, // loader drives data pins
	output logic [7:0] rdData // byte to loader
);
	logic [7:0] mem [0:255];
	logic [7:0] junk = 8'h5A;
	int lowCnt = 0;
	always @(posedge clock) begin
		junk <= ~junk;
		lowCnt <= (!selN && !readN) ? lowCnt + 1 : 0;
		if (!selN && !writeN && wrOe) begin
			mem[addr[7:0]] <= wrData;
		end
	end
	// valid only after access time, else a changing pattern
	assign rdData = (!selN && !readN && lowCnt >= ACCESS_CYC) ? mem[addr[7:0]] : junk;
endmodule : bootl_rom_model

// >>> bootl_loader_test.sv
// self-checking bench for the byte boot loader with its EPROM model
`timescale 1ns/1ns
module bootl_loader_test;
	localparam int WORDS = 6;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic bootEpromStrap = 1'b1;
	logic [7:0] romDataIn;
	logic [7:0] romDataOut;
	logic romDataOe;
	logic [23:0] romAddr;
	logic selN;
	logic readN;
	logic writeN;
	logic memWrValid;
	logic [15:0] memWrAddr;
	logic [31:0] memWrData;
	logic memWrReady = 1'b0;
	logic bootDone;
	logic dmaReq = 1'b0;
	logic dmaWrite = 1'b0;
	logic [23:0] dmaAddr = 24'h00_0004;
	logic [7:0] dmaWrData = 8'h00;
	logic dmaAck;
	logic [7:0] dmaRdData;
	logic [7:0] image [0:255];
	logic [47:0] expWords [$];
	logic [8:0] expAcks [$];
	logic [8:0] ackNote;
	logic [23:0] a;
	logic [7:0] d;
	int mismatches = 0;
	int samples_checked = 0;
	int lowRun = 0;
	bit stallDone = 1'b0;

	bootl_loader #(.BOOT_WORDS(WORDS)) u_dut (.clock(clock), .sys_rst(sys_rst),
		.bootEpromStrap(bootEpromStrap), .romDataIn(romDataIn), .romDataOut(romDataOut),
		.romDataOe(romDataOe), .romAddr(romAddr), .boot_memory_select_n(selN),
		.romRead_n(readN), .romWrite_n(writeN), .memWrValid(memWrValid),
		.memWrAddr(memWrAddr), .memWrData(memWrData), .memWrReady(memWrReady),
		.bootDone(bootDone), .dmaReq(dmaReq), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
		.dmaWrData(dmaWrData), .dmaAck(dmaAck), .dmaRdData(dmaRdData));
	bootl_rom_model u_rom (.clock(clock), .selN(selN), .readN(readN), .writeN(writeN),
		.addr(romAddr), .wrData(romDataOut), .wrOe(romDataOe), .rdData(romDataIn));

	initial begin
		forever #20 clock = ~clock;
	end

	task automatic fail(input string msg);
		mismatches++;
		$display("BAD %0t %s", $time, msg);
	endtask : fail
	task automatic check_word(input logic [47:0] got, input logic [47:0] exp);
		samples_checked++;
		if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
	endtask : check_word
	task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) fail($sformatf("byte %h expected %h", got, exp));
	endtask : check_byte
	task automatic check_flag(input logic got, input logic exp, input string what);
		samples_checked++;
		if (got !== exp) fail({what, " has wrong level"});
	endtask : check_flag
	task automatic check_count(input int got, input int exp);
		samples_checked++;
		if (got != exp) fail($sformatf("select low %0d cycles", got));
	endtask : check_count
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : complete_run
	task automatic wait_ack();
		for (int n = 0; n < 3000; n++) begin
			@(posedge clock);
			if (dmaAck === 1'b1) begin
				dmaReq <= 1'b0;
				return;
			end
		end
		fail("no access acknowledge");
		complete_run();
	endtask : wait_ack
	task automatic dma_access(input logic wr, input logic [23:0] ad, input logic [7:0] dt);
		expAcks.push_back({~wr, dt});
		@(posedge clock);
		dmaReq <= 1'b1;
		dmaWrite <= wr;
		dmaAddr <= ad;
		dmaWrData <= dt;
		wait_ack();
		check_word({24'h00_0000, romAddr}, {24'h00_0000, ad});
		repeat (20) @(posedge clock);
	endtask : dma_access

	// sink ready, held once raised until a word is seen
	always @(posedge clock) begin
		if (stallDone && (!memWrReady || memWrValid)) memWrReady <= ($urandom % 3) != 0;
	end

	always @(posedge clock) begin
		if (sys_rst) begin
			lowRun = 0;
		end else begin
			if (memWrValid === 1'b1 && memWrReady === 1'b1) begin
				if (expWords.size() == 0) fail("unexpected word");
				else check_word({memWrAddr, memWrData}, expWords.pop_front());
			end
			if (dmaAck === 1'b1) begin
				check_flag(bootDone, 1'b1, "done at acknowledge");
				if (expAcks.size() == 0) begin
					fail("unexpected acknowledge");
				end else begin
					ackNote = expAcks.pop_front();
					if (ackNote[8]) check_byte(dmaRdData, ackNote[7:0]);
				end
			end
			if (selN === 1'b0) begin
				lowRun++;
			end else if (lowRun != 0) begin
				check_count(lowRun, bootl_pkg::WAIT_CYCLES);
				lowRun = 0;
			end
			if (readN === 1'b0 && bootDone === 1'b0) check_flag(selN, 1'b0, "select");
		end
	end

	initial begin
		repeat (30000) @(posedge clock);
		fail("run too long");
		complete_run();
	end

	initial begin
		void'($urandom(30473));
		for (int i = 0; i < 256; i++) begin
			image[i] = 8'($urandom);
			u_rom.mem[i] = image[i];
		end
		for (int w = 0; w < WORDS; w++) begin
			expWords.push_back({16'(w), image[4*w+3], image[4*w+2], image[4*w+1], image[4*w]});
		end
		// read held from reset is refused until boot ends
		dmaReq <= 1'b1;
		expAcks.push_back({1'b1, image[4]});
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (500) @(posedge clock);
		stallDone = 1'b1;
		for (int n = 0; n < 3000 && bootDone !== 1'b1; n++) @(posedge clock);
		check_flag(bootDone, 1'b1, "boot done");
		wait_ack();
		repeat (20) @(posedge clock);
		for (int n = 0; n < 1000 && expWords.size() != 0; n++) @(posedge clock);
		check_word(48'(expWords.size()), 48'h0000_0000_0000);
		for (int k = 0; k < 4; k++) begin
			a = (k == 0) ? 24'hFF_FFFF : 24'($urandom);
			d = 8'($urandom);
			dma_access(1'b1, a, d);
			check_byte(u_rom.mem[a[7:0]], d);
			dma_access(1'b0, a, d);
		end
		@(posedge clock);
		sys_rst <= 1'b1;
		bootEpromStrap <= 1'b0;
		repeat (8) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (12) @(posedge clock);
		check_flag(bootDone, 1'b1, "done without boot");
		check_flag(selN, 1'b1, "idle select");
		complete_run();
	end
endmodule : bootl_loader_test
